// ===== logic/fast_timer_map.vh
`ifndef FAST_TIMER_MAP_VH
`define FAST_TIMER_MAP_VH

// register offsets on the 8-bit data bus
`define OFS_OVERRIDE_EN 6'h20
`define OFS_STAGE 6'h25
`define OFS_PLL_CSR 6'h29
`define OFS_CMP_D 6'h2A
`define OFS_PERIOD 6'h2B
`define OFS_CMP_B 6'h2C
`define OFS_CMP_A 6'h2D
`define OFS_COUNT_LOW 6'h2E
`define OFS_IRQ_FLAGS 6'h38
`define OFS_IRQ_MASK 6'h39

// pll control and status fields
`define PLL_LSM_BIT 7
`define PLL_FAST_CLOCK_SELECT_BIT 2
`define PLL_PLL_ENABLE_BIT_BIT 1
`define PLL_LOCK_BIT 0

// flag and mask fields (same layout in both registers)
`define IRQ_D_BIT 7
`define IRQ_A_BIT 6
`define IRQ_B_BIT 5
`define IRQ_OVF_BIT 2

// clock-select fuse value that makes the pll the system clock
`define FUSE_PLL_SYSCLK 4'h1

// smallest period value the period register will hold
`define PERIOD_MIN 10'h003

// interrupt vector numbers
`define VEC_NONE 5'h00
`define VEC_CMP_A 5'h03
`define VEC_OVF 5'h04
`define VEC_CMP_B 5'h09
`define VEC_CMP_D 5'h10

// reset values
`define RST_BYTE 8'h00
`define RST_COUNT 10'h000
`define RST_PERIOD 10'h3FF

`endif

// ===== logic/sync_2ff.v
`timescale 1ns/10ps
module sync_2ff #(
  parameter W = 1
) (
  input wire clk_in,
  input wire rst_in,
  input wire ce_in,
  input wire [W-1:0] d_in,
  output reg [W-1:0] q_out
);
  reg [W-1:0] meta_reg;

  // first stage feeds only the second stage
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_reg <= {W{1'b0}};
      q_out <= {W{1'b0}};
    end else if (ce_in) begin
      meta_reg <= d_in;
      q_out <= meta_reg;
    end
  end
endmodule // sync_2ff

// ===== logic/fast_pwm_timer_core_regs.v
// How it works
// [RULE1] six override bits gate a, b, d pins
// [RULE2] cleared override drives pin from port register
// [RULE3] low-speed select halves fast clock to 32 MHz
// [RULE4] low-speed set refused while pll is sysclk
// [RULE5] software stops timer before changing low-speed
// [RULE6] fast select picks pll clock, else sysclk
// [RULE7] fast select settable only with pll enabled
// [RULE8] pll enable starts pll, reads one if sysclk
// [RULE9] read-only lock flag follows pll lock
// [RULE10] pll bits 6:3 zero, bit 1 reset varies
// [RULE11] 10-bit up/down counter, read and write
// [RULE12] counter write lands 1.5 or 1 cycles later; code lands it 2 cycles later without fast select, 1 with it
// [RULE13] counter write restarts up counting
// [RULE14] shared stage holds bits 9:8, rest zero
// [RULE15] stage then low byte; low read loads stage
// [RULE16] match only while counting up, not writes
// [RULE17] match sets flag after a sync delay
// [RULE18] period match clears counter in single-slope modes; dual slope turns down there instead
// [RULE19] period below three is stored as three
// [RULE20] d, a, b enables in mask bits 7:5
// [RULE21] overflow sets flag bit 2, vector 4
// [RULE22] flags clear on vector taken or write one
// [RULE23] overflow at top, or bottom in dual slope
`timescale 1ns/10ps
`include "fast_timer_map.vh"
module fast_pwm_timer_core_regs (
  input wire clk_in,
  input wire rst_in,
  input wire ce_in,
  input wire [5:0] addr_in,
  input wire wr_en_in,
  input wire rd_en_in,
  input wire [7:0] wdata_in,
  output reg [7:0] rdata_out,
  input wire count_en_in,
  input wire pwm_mode_in,
  input wire [1:0] wave_mode_in,
  input wire [5:0] waveform_in,
  input wire [5:0] port_b_in,
  output reg [5:0] pin_b_out,
  input wire pll_lock_in,
  input wire [3:0] clock_select_fuse_in,
  output reg pll_enable_out,
  output reg fast_clock_sel_out,
  output reg low_speed_out,
  input wire global_irq_en_in,
  input wire [3:0] irq_ack_in,
  output reg [4:0] irq_vector_out,
  output reg [3:0] match_out
);

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  wire [4:0] pin_sync;
  sync_2ff #(.W(5)) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .d_in({pll_lock_in, clock_select_fuse_in}),
    .q_out(pin_sync)
  );

  // fuse is a strap: caught after reset release, not under reset
  reg [3:0] fuse_reg;
  reg fuse_valid_reg;
  reg [1:0] fuse_wait_reg;
  wire pll_is_sysclk;
  assign pll_is_sysclk = fuse_valid_reg && (fuse_reg == `FUSE_PLL_SYSCLK);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  reg [5:0] override_en_reg;
  reg [1:0] stage_reg;
  reg lsm_reg;
  reg fast_clock_select_reg;
  reg pll_enable_bit_reg;
  reg lock_reg;
  reg [9:0] count_reg;
  reg up_reg;
  reg [9:0] cmp_reg [0:2];
  reg [9:0] period_reg;
  wire [7:0] flags_reg;
  reg [3:0] flag_bit_reg;
  reg [7:0] mask_reg;
  reg half_reg;
  reg wr_pend1_reg;
  reg wr_pend2_reg;
  reg [9:0] wr_val_reg;
  reg [3:0] match_sync_reg;
  reg [3:0] clr_pend_reg;

  // flag index order: 0 = a, 1 = b, 2 = d, 3 = overflow
  function [2:0] flag_pos;
    input [1:0] idx;
    begin
      case (idx)
        2'd0: flag_pos = 3'd`IRQ_A_BIT;
        2'd1: flag_pos = 3'd`IRQ_B_BIT;
        2'd2: flag_pos = 3'd`IRQ_D_BIT;
        default: flag_pos = 3'd`IRQ_OVF_BIT;
      endcase
    end
  endfunction

  // compare registers share one decode for reads and writes
  function [1:0] cmp_index;
    input [5:0] a;
    begin
      case (a)
        `OFS_CMP_A: cmp_index = 2'd0;
        `OFS_CMP_B: cmp_index = 2'd1;
        `OFS_CMP_D: cmp_index = 2'd2;
        default: cmp_index = 2'd3;
      endcase
    end
  endfunction

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  wire wr_count;
  wire wr_period;
  wire wr_pll;
  wire wr_flags;
  wire [1:0] wr_cmp_idx;
  wire [9:0] wr_wide;
  wire pll_enabled;
  assign wr_count = wr_en_in && (addr_in == `OFS_COUNT_LOW);
  assign wr_period = wr_en_in && (addr_in == `OFS_PERIOD);
  assign wr_pll = wr_en_in && (addr_in == `OFS_PLL_CSR);
  assign wr_flags = wr_en_in && (addr_in == `OFS_IRQ_FLAGS);
  assign wr_cmp_idx = cmp_index(addr_in);
  // [RULE15] stage joins low byte
  assign wr_wide = {stage_reg, wdata_in};
  // [RULE8] pll on by bit or fuse
  assign pll_enabled = pll_enable_bit_reg || pll_is_sysclk;

  // ------------------------------------------------------------
  // counter next state
  // ------------------------------------------------------------
  reg tick;
  reg [9:0] count_next;
  reg up_next;
  reg ovf_ev;
  reg [2:0] cmp_ev;
  reg apply_wr;
  wire dual_slope;
  integer i;
  assign dual_slope = pwm_mode_in && wave_mode_in[0];

  always @* begin
    // [RULE6] clock source select
    // [RULE3] low speed halves fast ticks
    tick = count_en_in && !(fast_clock_select_reg && lsm_reg && !half_reg);
    // [RULE12] write lands after 1 or 2 edges
    apply_wr = (wr_pend1_reg && fast_clock_select_reg) || wr_pend2_reg;
    count_next = count_reg;
    up_next = up_reg;
    ovf_ev = 1'b0;
    cmp_ev = 3'b000;
    if (apply_wr) begin
      // [RULE13] write resumes up counting
      count_next = wr_val_reg;
      up_next = 1'b1;
    end else if (tick) begin
      // [RULE11] up/down count
      if (dual_slope) begin
        if (up_reg) begin
          if (count_reg >= period_reg) begin
            up_next = 1'b0;
            count_next = count_reg - 10'h001;
          end else begin
            count_next = count_reg + 10'h001;
          end
        end else if (count_reg == 10'h000) begin
          up_next = 1'b1;
          count_next = 10'h001;
        end else begin
          count_next = count_reg - 10'h001;
          // [RULE23] bottom overflow in dual slope
          ovf_ev = (count_reg == 10'h001);
          up_next = (count_reg == 10'h001);
        end
      end else if (count_reg >= period_reg) begin
        // [RULE18] period match clears counter
        // [RULE23] top overflow with reset to bottom
        count_next = 10'h000;
        ovf_ev = 1'b1;
      end else begin
        count_next = count_reg + 10'h001;
      end
      // [RULE16] match only while counting up
      for (i = 0; i < 3; i = i + 1) begin
        cmp_ev[i] = up_reg && (count_next == cmp_reg[i]) && (count_next != count_reg);
      end
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      fuse_reg <= 4'h0;
      fuse_valid_reg <= 1'b0;
      fuse_wait_reg <= 2'b00;
      override_en_reg <= 6'h00;
      stage_reg <= 2'b00;
      lsm_reg <= 1'b0;
      fast_clock_select_reg <= 1'b0;
      pll_enable_bit_reg <= 1'b0;
      lock_reg <= 1'b0;
      count_reg <= `RST_COUNT;
      up_reg <= 1'b1;
      period_reg <= `RST_PERIOD;
      mask_reg <= `RST_BYTE;
      half_reg <= 1'b0;
      wr_pend1_reg <= 1'b0;
      wr_pend2_reg <= 1'b0;
      wr_val_reg <= 10'h000;
      rdata_out <= `RST_BYTE;
    end else if (ce_in) begin
      // synchroniser restarts from zero, so wait until it holds the strap
      if (!fuse_valid_reg) begin
        if (fuse_wait_reg == 2'd2) begin
          fuse_reg <= pin_sync[3:0];
          fuse_valid_reg <= 1'b1;
        end else begin
          fuse_wait_reg <= fuse_wait_reg + 2'd1;
        end
      end
      // [RULE9] lock flag mirrors synced pll lock while pll enabled
      lock_reg <= pin_sync[4] && pll_enabled;
      if (count_en_in) begin
        half_reg <= !half_reg;
      end
      count_reg <= count_next;
      up_reg <= up_next;
      wr_pend1_reg <= wr_count;
      wr_pend2_reg <= wr_pend1_reg && !fast_clock_select_reg;
      if (wr_count) begin
        wr_val_reg <= wr_wide;
      end
      if (wr_en_in) begin
        case (addr_in)
          // [RULE1] six override enables
          `OFS_OVERRIDE_EN: override_en_reg <= wdata_in[5:0];
          // [RULE14] stage keeps two bits
          `OFS_STAGE: stage_reg <= wdata_in[1:0];
          `OFS_IRQ_MASK: mask_reg <= wdata_in;
          // [RULE19] period floor of three
          `OFS_PERIOD: period_reg <= (wr_wide < `PERIOD_MIN) ? `PERIOD_MIN : wr_wide;
          default: ;
        endcase
      end
      if (wr_pll) begin
        // [RULE4] low speed refused on pll sysclk
        lsm_reg <= wdata_in[`PLL_LSM_BIT] && !pll_is_sysclk;
        // [RULE7] fast select needs pll enabled earlier
        fast_clock_select_reg <= wdata_in[`PLL_FAST_CLOCK_SELECT_BIT] && pll_enabled;
        pll_enable_bit_reg <= wdata_in[`PLL_PLL_ENABLE_BIT_BIT];
      end
      rdata_out <= `RST_BYTE;
      if (rd_en_in) begin
        if (wr_cmp_idx != 2'd3) begin
          rdata_out <= cmp_reg[wr_cmp_idx][7:0];
          stage_reg <= cmp_reg[wr_cmp_idx][9:8];
        end
        case (addr_in)
          `OFS_COUNT_LOW: begin
            // [RULE15] low read loads stage
            rdata_out <= count_reg[7:0];
            stage_reg <= count_reg[9:8];
          end
          `OFS_PERIOD: begin
            rdata_out <= period_reg[7:0];
            stage_reg <= period_reg[9:8];
          end
          // [RULE14] upper stage bits read zero
          `OFS_STAGE: rdata_out <= {6'h00, stage_reg};
          `OFS_OVERRIDE_EN: rdata_out <= {2'b00, override_en_reg};
          // [RULE10] reserved bits zero, bit 1 tracks source
          `OFS_PLL_CSR: rdata_out <= {lsm_reg, 4'h0, fast_clock_select_reg, pll_enabled, lock_reg};
          `OFS_IRQ_FLAGS: rdata_out <= flags_reg;
          `OFS_IRQ_MASK: rdata_out <= mask_reg;
          default: ;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // compare registers
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_cmp
      always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          cmp_reg[g] <= 10'h000;
        end else if (ce_in && wr_en_in && (wr_cmp_idx == g)) begin
          cmp_reg[g] <= wr_wide;
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // interrupt flags
  // ------------------------------------------------------------
  wire [3:0] event_now;
  assign event_now = {ovf_ev, cmp_ev[2], cmp_ev[1], cmp_ev[0]};
  // bits not owned by this timer stay zero
  assign flags_reg = {flag_bit_reg[2], flag_bit_reg[0], flag_bit_reg[1], 2'b00,
    flag_bit_reg[3], 2'b00};

  generate
    for (g = 0; g < 4; g = g + 1) begin : g_flag
      always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          match_sync_reg[g] <= 1'b0;
          clr_pend_reg[g] <= 1'b0;
          flag_bit_reg[g] <= 1'b0;
        end else if (ce_in) begin
          // [RULE17] one sync stage before flag
          match_sync_reg[g] <= event_now[g];
          // [RULE22] write one clears a cycle later
          clr_pend_reg[g] <= wr_flags && wdata_in[flag_pos(g)];
          // [RULE21] overflow sets bit 2; set wins over clear
          if (match_sync_reg[g]) begin
            flag_bit_reg[g] <= 1'b1;
          end else if (clr_pend_reg[g] || irq_ack_in[g]) begin
            flag_bit_reg[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  wire [7:0] pending;
  assign pending = flags_reg & mask_reg & {8{global_irq_en_in}};

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_b_out <= 6'h00;
      pll_enable_out <= 1'b0;
      fast_clock_sel_out <= 1'b0;
      low_speed_out <= 1'b0;
      irq_vector_out <= `VEC_NONE;
      match_out <= 4'h0;
    end else if (ce_in) begin
      // [RULE2] cleared override selects port register
      pin_b_out <= (override_en_reg & waveform_in) | (~override_en_reg & port_b_in);
      // [RULE8] pll runs when enabled
      pll_enable_out <= pll_enabled;
      fast_clock_sel_out <= fast_clock_select_reg;
      low_speed_out <= lsm_reg;
      match_out <= event_now;
      // [RULE20] lowest vector number first
      if (pending[`IRQ_A_BIT]) begin
        irq_vector_out <= `VEC_CMP_A;
      end else if (pending[`IRQ_OVF_BIT]) begin
        // [RULE21] overflow vector
        irq_vector_out <= `VEC_OVF;
      end else if (pending[`IRQ_B_BIT]) begin
        irq_vector_out <= `VEC_CMP_B;
      end else if (pending[`IRQ_D_BIT]) begin
        irq_vector_out <= `VEC_CMP_D;
      end else begin
        irq_vector_out <= `VEC_NONE;
      end
    end
  end

endmodule // fast_pwm_timer_core_regs

// ===== sim/timer_regs_props.sv
`timescale 1ns/10ps
`include "fast_timer_map.vh"
module timer_regs_checker (
  input wire clk_in,
  input wire rst_in,
  input wire [5:0] addr_in,
  input wire wr_en_in,
  input wire rd_en_in,
  input wire [7:0] rdata_out,
  input wire [5:0] waveform_in,
  input wire [5:0] port_b_in,
  input wire [5:0] pin_b_out,
  input wire [3:0] clock_select_fuse_in,
  input wire pll_enable_out,
  input wire fast_clock_sel_out,
  input wire low_speed_out,
  input wire global_irq_en_in,
  input wire [4:0] irq_vector_out,
  input wire [3:0] match_out
);
  // ----------------------------------------
  // settle tracking
  // ----------------------------------------
  // the fuse is captured once after reset, so a mid-run change voids the fuse checks
  logic [2:0] age_reg;
  logic [3:0] fuse_reg;
  logic moved_reg;
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      age_reg <= 3'h0;
      moved_reg <= 1'b0;
      fuse_reg <= clock_select_fuse_in;
    end else begin
      fuse_reg <= clock_select_fuse_in;
      if (fuse_reg != clock_select_fuse_in) moved_reg <= 1'b1;
      if (age_reg != 3'h7) age_reg <= age_reg + 3'h1;
    end
  end
  wire ready = age_reg == 3'h7 && !moved_reg;
  wire fuse_pll = clock_select_fuse_in == `FUSE_PLL_SYSCLK;
  wire pll_wr = wr_en_in && addr_in == `OFS_PLL_CSR;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_pll_reserved_zero:
    assert property (rd_en_in && addr_in == `OFS_PLL_CSR |=> rdata_out[6:3] == 4'h0)
    else $error("pll reserved bits set");
  a_stage_upper_zero:
    assert property (rd_en_in && addr_in == `OFS_STAGE |=> rdata_out[7:2] == 6'h00)
    else $error("stage upper bits set");
  a_lsm_refused:
    assert property (ready && fuse_pll |-> !low_speed_out)
    else $error("low speed set on pll system clock");
  a_pll_reads_one:
    assert property (ready && fuse_pll |-> pll_enable_out)
    else $error("pll enable low on pll system clock");
  a_fast_sel_refused:
    assert property (ready && pll_wr && !pll_enable_out && !fast_clock_sel_out
      |-> ##2 !fast_clock_sel_out)
    else $error("fast select set without pll");
  a_vec_needs_gie:
    assert property (irq_vector_out != `VEC_NONE |-> $past(global_irq_en_in))
    else $error("vector without global enable");
  a_vec_codes:
    assert property (irq_vector_out inside {`VEC_NONE, `VEC_CMP_A, `VEC_OVF,
      `VEC_CMP_B, `VEC_CMP_D})
    else $error("illegal vector code");
  a_pin_follows_port:
    assert property (ready && waveform_in == port_b_in |=> pin_b_out == $past(port_b_in))
    else $error("pin differs from common source");
  a_match_single:
    assert property (match_out[0] |=> !match_out[0])
    else $error("match a held two cycles");
  c_vec_a: cover property (irq_vector_out == `VEC_CMP_A);
  c_overflow: cover property (match_out[3]);
  c_fast_low: cover property (fast_clock_sel_out && low_speed_out);
endmodule // timer_regs_checker
bind fast_pwm_timer_core_regs timer_regs_checker props_i (.clk_in, .rst_in, .addr_in,
  .wr_en_in, .rd_en_in, .rdata_out, .waveform_in, .port_b_in, .pin_b_out,
  .clock_select_fuse_in, .pll_enable_out, .fast_clock_sel_out, .low_speed_out,
  .global_irq_en_in, .irq_vector_out, .match_out);

// ===== sim/cpu_bus_model.sv
`timescale 1ns/10ps
`include "fast_timer_map.vh"
module cpu_bus_model (
  input wire clk_in,
  input wire [7:0] rdata_in,
  output logic [5:0] addr_out,
  output logic wr_out,
  output logic rd_out,
  output logic [7:0] wdata_out
);
  // ----------------------------------------
  // byte accesses
  // ----------------------------------------
  initial begin
    addr_out = 6'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
    wdata_out = 8'h00;
  end
  // idle lines show the inverse so a stale value is never mistaken for a live one
  task wr(input logic [5:0] a, input logic [7:0] v);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= v;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~v;
  endtask
  task rd(input logic [5:0] a, output logic [7:0] v);
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
    #1;
    v = rdata_in;
  endtask
  task wr10(input logic [5:0] a, input logic [9:0] v);
    wr(`OFS_STAGE, {6'h00, v[9:8]});
    wr(a, v[7:0]);
  endtask
endmodule // cpu_bus_model

// ===== sim/fast_pwm_timer_core_regs_tb.sv
`timescale 1ns/10ps
`include "fast_timer_map.vh"
module fast_pwm_timer_core_regs_tb;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic cnt_en = 1'b0;
  logic gie = 1'b0;
  logic lock = 1'b0;
  logic [3:0] fuse = 4'h0;
  logic [3:0] ack = 4'h0;
  logic [5:0] wave = 6'h2A;
  logic [5:0] port = 6'h15;
  logic [5:0] addr, pins;
  logic wr_en, rd_en, pll_en, fast_sel, low_spd;
  logic [7:0] wdata, rdata, d;
  logic [4:0] vec;
  logic [3:0] match;
  int bad_count = 0;
  int num_checks = 0;
  always #50 clk_in = ~clk_in;
  cpu_bus_model cpu (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr), .wr_out(wr_en),
    .rd_out(rd_en), .wdata_out(wdata));
  fast_pwm_timer_core_regs uut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1),
    .addr_in(addr), .wr_en_in(wr_en), .rd_en_in(rd_en), .wdata_in(wdata), .rdata_out(rdata),
    .count_en_in(cnt_en), .pwm_mode_in(1'b0), .wave_mode_in(2'h0), .waveform_in(wave),
    .port_b_in(port), .pin_b_out(pins), .pll_lock_in(lock), .clock_select_fuse_in(fuse),
    .pll_enable_out(pll_en), .fast_clock_sel_out(fast_sel), .low_speed_out(low_spd),
    .global_irq_en_in(gie), .irq_ack_in(ack), .irq_vector_out(vec), .match_out(match));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task rc(input logic [5:0] a, input logic [7:0] e);
    cpu.rd(a, d);
    chk(d, e);
  endtask
  task wait_vec(input logic [4:0] e);
    for (int i = 0; i < 40 && vec !== e; i++) @(posedge clk_in) #1;
    chk({3'h0, vec}, {3'h0, e});
  endtask
  // fuse moves before reset; reset clears its synchroniser, which refills after release
  task do_reset(input logic [3:0] f);
    fuse <= f;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (8) @(posedge clk_in);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task s_regs;
    rc(`OFS_IRQ_MASK, 8'h00);
    rc(`OFS_IRQ_FLAGS, 8'h00);
    rc(`OFS_PLL_CSR, 8'h00);
    cpu.wr(`OFS_STAGE, 8'hFF);
    rc(`OFS_STAGE, 8'h03);
    cpu.wr10(`OFS_COUNT_LOW, 10'h2B4);
    repeat (2) @(posedge clk_in);
    rc(`OFS_COUNT_LOW, 8'hB4);
    rc(`OFS_STAGE, 8'h02);
    cpu.wr10(`OFS_PERIOD, 10'h001);
    rc(`OFS_PERIOD, 8'h03);
    rc(`OFS_STAGE, 8'h00);
  endtask
  task s_pll;
    cpu.wr(`OFS_PLL_CSR, 8'h04);
    rc(`OFS_PLL_CSR, 8'h00);
    cpu.wr(`OFS_PLL_CSR, 8'h02);
    rc(`OFS_PLL_CSR, 8'h02);
    @(posedge clk_in);
    lock <= 1'b1;
    repeat (4) @(posedge clk_in);
    rc(`OFS_PLL_CSR, 8'h03);
    cpu.wr(`OFS_PLL_CSR, 8'hFE);
    rc(`OFS_PLL_CSR, 8'h87);
    chk({5'h00, pll_en, fast_sel, low_spd}, 8'h07);
    cpu.wr(`OFS_PLL_CSR, 8'h02);
  endtask
  task s_ovf;
    cpu.wr(`OFS_IRQ_MASK, 8'h04);
    @(posedge clk_in);
    cnt_en <= 1'b1;
    repeat (12) @(posedge clk_in);
    chk({3'h0, vec}, 8'h00);
    gie <= 1'b1;
    wait_vec(`VEC_OVF);
    @(posedge clk_in);
    cnt_en <= 1'b0;
    repeat (3) @(posedge clk_in);
    ack <= 4'h8;
    @(posedge clk_in);
    ack <= 4'h0;
    cpu.rd(`OFS_IRQ_FLAGS, d);
    chk(d & 8'h04, 8'h00);
    cpu.wr(`OFS_IRQ_FLAGS, 8'hFF);
    rc(`OFS_IRQ_FLAGS, 8'h00);
  endtask
  task s_match;
    logic [5:0] ofs [3];
    logic [7:0] bits [3];
    logic [4:0] vecs [3];
    ofs = '{`OFS_CMP_A, `OFS_CMP_B, `OFS_CMP_D};
    bits = '{8'h40, 8'h20, 8'h80};
    vecs = '{`VEC_CMP_A, `VEC_CMP_B, `VEC_CMP_D};
    for (int k = 0; k < 3; k++) begin
      cpu.wr10(ofs[k], 10'h002);
      cpu.wr10(`OFS_COUNT_LOW, 10'h002);
      repeat (3) @(posedge clk_in);
      rc(`OFS_IRQ_FLAGS, 8'h00);
      cpu.wr(`OFS_IRQ_MASK, bits[k]);
      @(posedge clk_in);
      cnt_en <= 1'b1;
      wait_vec(vecs[k]);
      @(posedge clk_in);
      cnt_en <= 1'b0;
      repeat (3) @(posedge clk_in);
      ack <= 4'h1 << k;
      @(posedge clk_in);
      ack <= 4'h0;
      cpu.rd(`OFS_IRQ_FLAGS, d);
      chk(d & bits[k], 8'h00);
      cpu.wr(`OFS_IRQ_FLAGS, 8'hFF);
    end
  endtask
  task s_override;
    logic [5:0] en [3];
    en = '{6'h00, 6'h3F, 6'h15};
    for (int k = 0; k < 3; k++) begin
      cpu.wr(`OFS_OVERRIDE_EN, {2'h0, en[k]});
      repeat (2) @(posedge clk_in);
      #1;
      chk({2'h0, pins}, {2'h0, (wave & en[k]) | (port & ~en[k])});
    end
    @(posedge clk_in);
    wave <= port;
    repeat (3) @(posedge clk_in);
  endtask
  task s_fuse;
    do_reset(4'h1);
    chk({7'h00, pll_en}, 8'h01);
    rc(`OFS_PLL_CSR, 8'h03);
    cpu.wr(`OFS_PLL_CSR, 8'h84);
    rc(`OFS_PLL_CSR, 8'h07);
    chk({6'h00, fast_sel, low_spd}, 8'h02);
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    do_reset(4'h0);
    s_regs;
    s_pll;
    s_ovf;
    s_match;
    s_override;
    s_fuse;
    tally_and_finish;
  end
  // the whole run needs well under a thousand cycles
  initial begin
    #500_000;
    bad_count++;
    tally_and_finish;
  end
endmodule // fast_pwm_timer_core_regs_tb
